// ---- tb.sv ----
// Register-level bench for the host port state control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rstn, awv, wv, brdy, arv, rrdy, pm, att, chok, wake;
  logic        awr, wrd, bv, arr, rv, dcon, dchp, dwk;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0]  br, rr, rs;
  logic [4:0]  tv;
  logic [7:0]  cmd [12] = '{8'h2, 8'h3, 8'h1, 8'h4, 8'h5, 8'h6, 8'h7, 8'ha, 8'h9, 8'hc, 8'he, 8'hf};
  logic [2:0]  nxt [12] = '{3'h2, 3'h3, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h5, 3'h3, 3'h5, 3'h5, 3'h5};
  logic [1:0]  sp [3] = '{2'h0, 2'h1, 2'h3};
  int          mismatches, total_checks, cyc, n;
  uhpsc_pkg::uhpsc_line_t lc;
  assign tv = {lc.sof_en, lc.hs_rx, lc.drive_j, lc.drive_k, lc.pkt_frame};
  uhpsc_ctrl #(.BUS_RESET_CYC(24'hc), .CHIRP_WAIT_CYC(24'hc), .HOST_CHIRP_CYC(24'h8),
    .RESUME_CYC(24'hc)) dut (.MCLK(mclk), .RESETN(rstn), .AWADDR(awa), .AWVALID(awv),
    .AWREADY(awr), .WDATA(wd), .WSTRB(4'hf), .WVALID(wv), .WREADY(wrd), .BRESP(br),
    .BVALID(bv), .BREADY(brdy), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr), .RDATA(rdat),
    .RRESP(rr), .RVALID(rv), .RREADY(rrdy), .PM_ACTIVE(pm), .DEV_CONNECT(dcon),
    .DEV_CHIRP_DONE(dchp), .REMOTE_WAKE(dwk), .LINE_CTRL(lc));
  uhpsc_dev_model peer (.clk(mclk), .rst_n(rstn), .line(lc), .attach(att), .chirp_ok(chok),
    .wake_req(wake), .connect(dcon), .chirp_done(dchp), .remote_wake(dwk));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
      $display("FAIL %s expected %h seen %h", s, exp, seen);
    if (seen !== exp)
      mismatches++;
  endtask : chk
  // One AXI4-Lite write or read, held until its response
  task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] v);
    @(posedge mclk);
    {awa, ara, wd} <= {i, 2'h0, i, 2'h0, 24'h0, v};
    {awv, wv, brdy, arv, rrdy} <= {w, w, w, !w, !w};
    do
    begin
      @(posedge mclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (arr) arv <= 1'b0;
    end
    while ((w ? bv : rv) !== 1'b1);
    d = rdat;
    rs = w ? br : rr;
    {brdy, rrdy} <= 2'h0;
  endtask : bus
  task automatic poll(input string s, input logic [9:0] i, input logic [7:0] m, e);
    n = 0;
    do
    begin
      bus(1'b0, i, 8'h0);
      n++;
    end
    while ((d[7:0] & m) !== e && n < 60);
    chk(s, d[7:0] & m, e);
  endtask : poll
  task automatic go(input logic [7:0] c);
    bus(1'b1, 10'h160, 8'h80);
    bus(1'b0, 10'h160, 8'h0);
    chk("halt_set", d[7], 1'b1);
    poll("halt_clr", 10'h160, 8'h80, 8'h00);
    if (c != 8'h00) bus(1'b1, 10'h160, c);
  endtask : go
  initial
  begin
    {rstn, awv, wv, brdy, arv, rrdy, chok, wake, awa, ara, wd} = '0;
    {pm, att} = 2'h3;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    bus(1'b0, 10'h160, 8'h0);
    chk("lo_reset", d, 32'h10);
    bus(1'b0, 10'h162, 8'h0);
    chk("hi_reset", d, 32'h10);
    bus(1'b0, 10'h3ff, 8'h0);
    chk("unmapped", rs, uhpsc_pkg::RESP_SLVERR);
    bus(1'b1, 10'h3ff, 8'h0);
    chk("unmapped_wr", rs, uhpsc_pkg::RESP_SLVERR);
    foreach (sp[k])
    begin
      bus(1'b1, 10'h162, {2'h0, sp[k], 4'h3});
      bus(1'b0, 10'h162, 8'h0);
      chk("nego_hi", d, {26'h0, sp[k], 4'h3});
    end
    pm <= 1'b0;
    bus(1'b0, 10'h162, 8'h0);
    chk("hi_pm_off", d, 32'h0);
    pm <= 1'b1;
    foreach (cmd[k])
    begin
      if (k == 10) wake <= 1'b1;
      go(cmd[k]);
      poll("state", 10'h160, 8'h70, {1'b0, nxt[k], 4'h0});
    end
    bus(1'b1, 10'h162, 8'h01);
    chk("wr_okay", rs, uhpsc_pkg::RESP_OKAY);
    bus(1'b1, 10'h166, 8'h07);
    go(8'h0c);
    poll("chirp_err", 10'h166, 8'h05, 8'h05);
    bus(1'b1, 10'h162, 8'h03);
    bus(1'b1, 10'h166, 8'h07);
    go(8'h0c);
    repeat (40) @(posedge mclk);
    chk("bus_reset", lc.bus_reset, 1'b1);
    poll("chirp_wait", 10'h166, 8'h05, 8'h01);
    chok <= 1'b1;
    poll("chirp_late", 10'h160, 8'h70, 8'h50);
    // Unplug while frozen must not move the state
    go(8'h00);
    att <= 1'b0;
    repeat (20) @(posedge mclk);
    bus(1'b0, 10'h160, 8'h0);
    chk("frozen", d[6:4], 3'h5);
    bus(1'b1, 10'h160, 8'h05);
    poll("unplug", 10'h160, 8'h70, 8'h20);
    att <= 1'b1;
    // Full speed outside test, so forced high speed is visible
    bus(1'b1, 10'h162, 8'h13);
    for (int b = 0; b < 5; b++)
    begin
      go(8'h03);
      poll("disabled", 10'h160, 8'h70, 8'h30);
      go(8'h00);
      bus(1'b1, 10'h164, 8'h80 | (8'h01 << b));
      repeat (20) @(posedge mclk);
      chk("test_line", tv, 32'h1 << b);
      chk("test_speed", lc.speed, uhpsc_pkg::SPD_HS);
      bus(1'b1, 10'h164, 8'h00);
      poll("test_end", 10'h160, 8'h70, 8'h10);
    end
    go(8'h00);
    bus(1'b1, 10'h164, 8'h84);
    repeat (20) @(posedge mclk);
    chk("idle_refused", tv, 32'h0);
    stop_test();
  end
endmodule : tb

// ---- uhpsc_chk.sv ----
// Port assertions for the host port state control block
module uhpsc_chk (
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic [11:0] AWADDR,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic [11:0] ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic        PM_ACTIVE,
  input wire uhpsc_pkg::uhpsc_line_t LINE_CTRL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);
  sequence s_wr_take;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_halt_wr;
    s_wr_take ##0 (AWADDR[11:2] == uhpsc_pkg::NEGO_LO_IDX && WDATA[7]);
  endsequence
  sequence s_hi_rd_off;
    ARVALID && ARREADY && ARADDR[11:2] == uhpsc_pkg::NEGO_HI_IDX && !PM_ACTIVE;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##[1:2] BVALID)
    else $error("write not answered");
  a_halt_freeze: assert property (s_halt_wr |-> ##5 $stable(LINE_CTRL) [*6])
    else $error("line moved while halted");
  a_hi_pm_zero: assert property (s_hi_rd_off |=> RDATA == 32'h0)
    else $error("control read not zero");
  a_rd_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read not answered");
  a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_jk_excl: assert property (!(LINE_CTRL.drive_j && LINE_CTRL.drive_k))
    else $error("J and K together");
  a_hsrx_speed: assert property (LINE_CTRL.hs_rx
    |-> LINE_CTRL.speed == uhpsc_pkg::SPD_HS)
    else $error("receive not high speed");
  a_pkt_pid: assert property (LINE_CTRL.pkt_frame
    |-> LINE_CTRL.tx_pid == uhpsc_pkg::DATA0_PID)
    else $error("packet PID wrong");
endmodule : uhpsc_chk

bind uhpsc_ctrl uhpsc_chk u_chk (.MCLK, .RESETN, .AWADDR, .AWVALID, .AWREADY, .WDATA,
  .WVALID, .WREADY, .BVALID, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY,
  .PM_ACTIVE, .LINE_CTRL);

// ---- uhpsc_ctrl.sv ----
// Host port state control with test modes, AXI4-Lite register slave
module uhpsc_ctrl #(
  parameter logic [uhpsc_pkg::TMR_W-1:0] BUS_RESET_CYC  = 24'h0003e8,
  parameter logic [uhpsc_pkg::TMR_W-1:0] CHIRP_WAIT_CYC = 24'h0001f4,
  parameter logic [uhpsc_pkg::TMR_W-1:0] HOST_CHIRP_CYC = 24'h0000c8,
  parameter logic [uhpsc_pkg::TMR_W-1:0] RESUME_CYC     = 24'h0003e8
) (
  input  wire logic                            MCLK,
  input  wire logic                            RESETN,
  input  wire logic [uhpsc_pkg::ADDR_W-1:0]    AWADDR,
  input  wire logic                            AWVALID,
  output logic                                 AWREADY,
  input  wire logic [31:0]                     WDATA,
  input  wire logic [3:0]                      WSTRB,
  input  wire logic                            WVALID,
  output logic                                 WREADY,
  output logic [1:0]                           BRESP,
  output logic                                 BVALID,
  input  wire logic                            BREADY,
  input  wire logic [uhpsc_pkg::ADDR_W-1:0]    ARADDR,
  input  wire logic                            ARVALID,
  output logic                                 ARREADY,
  output logic [31:0]                          RDATA,
  output logic [1:0]                           RRESP,
  output logic                                 RVALID,
  input  wire logic                            RREADY,
  input  wire logic                            PM_ACTIVE,
  input  wire logic                            DEV_CONNECT,
  input  wire logic                            DEV_CHIRP_DONE,
  input  wire logic                            REMOTE_WAKE,
  output uhpsc_pkg::uhpsc_line_t               LINE_CTRL
);

  logic [uhpsc_pkg::IDX_W-1:0] aw_idx_r;
  logic [7:0]                  wbyte_r;
  logic                        wlane_r;
  logic                        wr_go;
  logic                        wr_map;
  logic                        rd_map;
  logic [uhpsc_pkg::IDX_W-1:0] ar_idx;
  logic [7:0]                  rd_byte;
  logic                        wr_lo;
  logic                        wr_hi;
  logic                        wr_test;
  logic                        wr_stat;
  logic [7:0]                  nego_hi_r;
  logic [7:0]                  test_r;
  logic [7:0]                  stat_r;
  logic                        halt_r;
  logic                        frozen_r;
  logic [uhpsc_pkg::HCNT_W-1:0] halt_cnt_r;
  logic                        test_act_r;
  logic                        chain_r;
  logic                        chirp_to_r;
  logic                        chirp_err_p_r;
  logic                        rst_done_p_r;
  logic                        tmr_load_r;
  logic [uhpsc_pkg::TMR_W-1:0] tmr_val_r;
  logic                        tmr_expired;
  logic                        tmr_hit;
  logic                        auto_run;
  logic                        wake_det;
  logic                        cmd_ok;
  logic                        test_ok;
  logic [3:0]                  cmd;
  uhpsc_pkg::uhpsc_state_t     state_r;
  uhpsc_pkg::uhpsc_state_t     chain_tgt_r;
  uhpsc_pkg::uhpsc_rph_t       rph_r;
  uhpsc_pkg::uhpsc_line_t      line_nxt;

  // Write channel: address and data taken in either order
  assign wr_go   = ~AWREADY & ~WREADY & ~BVALID;
  assign wr_map  = (aw_idx_r == uhpsc_pkg::NEGO_LO_IDX) || (aw_idx_r == uhpsc_pkg::NEGO_HI_IDX)
                || (aw_idx_r == uhpsc_pkg::TEST_IDX) || (aw_idx_r == uhpsc_pkg::PORT_STAT_IDX);
  assign wr_lo   = wr_go & wlane_r & (aw_idx_r == uhpsc_pkg::NEGO_LO_IDX);
  assign wr_hi   = wr_go & wlane_r & (aw_idx_r == uhpsc_pkg::NEGO_HI_IDX);
  assign wr_test = wr_go & wlane_r & (aw_idx_r == uhpsc_pkg::TEST_IDX);
  assign wr_stat = wr_go & wlane_r & (aw_idx_r == uhpsc_pkg::PORT_STAT_IDX);

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      AWREADY  <= 1'b1;
      WREADY   <= 1'b1;
      BVALID   <= 1'b0;
      BRESP    <= uhpsc_pkg::RESP_OKAY;
      aw_idx_r <= '0;
      wbyte_r  <= '0;
      wlane_r  <= 1'b0;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        AWREADY  <= 1'b0;
        aw_idx_r <= AWADDR[uhpsc_pkg::ADDR_W-1:2];
      end
      if (WVALID && WREADY)
      begin
        WREADY  <= 1'b0;
        wbyte_r <= WDATA[7:0];
        wlane_r <= WSTRB[0];
      end
      if (wr_go)
      begin
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
        BVALID  <= 1'b1;
        BRESP   <= wr_map ? uhpsc_pkg::RESP_OKAY : uhpsc_pkg::RESP_SLVERR;
      end
      else if (BVALID && BREADY)
      begin
        BVALID <= 1'b0;
      end
    end
  end

  // Read channel
  assign ar_idx = ARADDR[uhpsc_pkg::ADDR_W-1:2];
  assign rd_map = (ar_idx == uhpsc_pkg::NEGO_LO_IDX) || (ar_idx == uhpsc_pkg::NEGO_HI_IDX)
               || (ar_idx == uhpsc_pkg::TEST_IDX) || (ar_idx == uhpsc_pkg::PORT_STAT_IDX);

  always_comb
  begin
    rd_byte = 8'h00;
    if (ar_idx == uhpsc_pkg::NEGO_LO_IDX)
    begin
      rd_byte = {halt_r, state_r, 4'h0};
    end
    else if (ar_idx == uhpsc_pkg::NEGO_HI_IDX)
    begin
      rd_byte = PM_ACTIVE ? nego_hi_r : 8'h00;
    end
    else if (ar_idx == uhpsc_pkg::TEST_IDX)
    begin
      rd_byte = test_r;
    end
    else if (ar_idx == uhpsc_pkg::PORT_STAT_IDX)
    begin
      rd_byte = stat_r;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= '0;
      RRESP   <= uhpsc_pkg::RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= {24'h000000, rd_byte};
      RRESP   <= rd_map ? uhpsc_pkg::RESP_OKAY : uhpsc_pkg::RESP_SLVERR;
    end
    else if (RVALID && RREADY)
    begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // Software registers; hardware set wins over write-one clear
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      nego_hi_r <= uhpsc_pkg::NEGO_HI_RST;
      test_r    <= uhpsc_pkg::TEST_RST;
      stat_r    <= uhpsc_pkg::STAT_RST;
    end
    else
    begin
      if (wr_hi)
      begin
        nego_hi_r <= wbyte_r & uhpsc_pkg::NEGO_HI_MASK;
      end
      if (wr_test)
      begin
        test_r <= wbyte_r & uhpsc_pkg::TEST_MASK;
      end
      stat_r <= (stat_r & ~(wr_stat ? wbyte_r : 8'h00))
              | {5'h00, rst_done_p_r, wake_det, chirp_err_p_r};
    end
  end

  // Halt: stop automatic handling, then self-clear
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      halt_r     <= 1'b0;
      halt_cnt_r <= '0;
    end
    else if (wr_lo && wbyte_r[uhpsc_pkg::HALT_BIT])
    begin
      halt_r     <= 1'b1;
      halt_cnt_r <= '0;
    end
    else if (halt_r)
    begin
      halt_cnt_r <= halt_cnt_r + 1'b1;
      if (halt_cnt_r == uhpsc_pkg::HCNT_W'(uhpsc_pkg::HALT_STOP_CYC - 1))
      begin
        halt_r <= 1'b0;
      end
    end
  end

  assign cmd      = wbyte_r[3:0];
  assign cmd_ok   = wr_lo & ~wbyte_r[uhpsc_pkg::HALT_BIT] & ~halt_r
                  & (cmd inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                 4'h9, 4'ha, 4'hc, 4'he, 4'hf});
  assign test_ok  = wr_test & wbyte_r[uhpsc_pkg::ARM_BIT]
                  & (|(wbyte_r & uhpsc_pkg::TEST_SEL_MSK))
                  & frozen_r & ~halt_r
                  & (state_r inside {uhpsc_pkg::HST_WAIT_CON, uhpsc_pkg::HST_DISABLED,
                                     uhpsc_pkg::HST_SUSPEND});
  assign auto_run = ~halt_r & ~frozen_r;
  assign tmr_hit  = tmr_expired & ~tmr_load_r;
  assign wake_det = auto_run & nego_hi_r[uhpsc_pkg::WAKE_EN_BIT]
                  & (state_r == uhpsc_pkg::HST_SUSPEND) & REMOTE_WAKE;

  uhpsc_timer u_timer (
    .clk      (MCLK),
    .rst_n    (RESETN),
    .load     (tmr_load_r),
    .load_val (tmr_val_r),
    .run      (auto_run),
    .expired  (tmr_expired)
  );

  // Host state sequencing
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_r       <= uhpsc_pkg::HST_IDLE;
      chain_tgt_r   <= uhpsc_pkg::HST_OPER;
      chain_r       <= 1'b0;
      rph_r         <= uhpsc_pkg::RPH_DONE;
      chirp_to_r    <= 1'b0;
      chirp_err_p_r <= 1'b0;
      rst_done_p_r  <= 1'b0;
      frozen_r      <= 1'b0;
      test_act_r    <= 1'b0;
      tmr_load_r    <= 1'b0;
      tmr_val_r     <= '0;
    end
    else
    begin
      tmr_load_r    <= 1'b0;
      chirp_err_p_r <= 1'b0;
      rst_done_p_r  <= 1'b0;
      if (halt_r)
      begin
        frozen_r <= 1'b1;
      end
      if (wr_test && wbyte_r == 8'h00)
      begin
        test_act_r <= 1'b0;
        state_r    <= uhpsc_pkg::HST_IDLE;
        chain_r    <= 1'b0;
        frozen_r   <= 1'b0;
      end
      else if (test_ok)
      begin
        test_act_r <= 1'b1;
      end
      else if (cmd_ok && !test_act_r)
      begin
        frozen_r   <= 1'b0;
        chain_r    <= cmd[3];
        chirp_to_r <= 1'b0;
        chain_tgt_r <= (cmd == uhpsc_pkg::CMD_WC_DIS) ? uhpsc_pkg::HST_DISABLED
                                                      : uhpsc_pkg::HST_OPER;
        case (cmd)
          uhpsc_pkg::CMD_IDLE:     state_r <= uhpsc_pkg::HST_IDLE;
          uhpsc_pkg::CMD_WAIT_CON: state_r <= uhpsc_pkg::HST_WAIT_CON;
          uhpsc_pkg::CMD_WC_DIS:   state_r <= uhpsc_pkg::HST_WAIT_CON;
          uhpsc_pkg::CMD_WC_OP:    state_r <= uhpsc_pkg::HST_WAIT_CON;
          uhpsc_pkg::CMD_DISABLED: state_r <= uhpsc_pkg::HST_DISABLED;
          uhpsc_pkg::CMD_OPER:     state_r <= uhpsc_pkg::HST_OPER;
          uhpsc_pkg::CMD_SUSPEND:  state_r <= uhpsc_pkg::HST_SUSPEND;
          uhpsc_pkg::CMD_SUS_OP:   state_r <= uhpsc_pkg::HST_SUSPEND;
          uhpsc_pkg::CMD_RESET, uhpsc_pkg::CMD_RST_OP:
          begin
            state_r    <= uhpsc_pkg::HST_RESET;
            rph_r      <= uhpsc_pkg::RPH_DRIVE;
            tmr_load_r <= 1'b1;
            tmr_val_r  <= (nego_hi_r[5:4] == uhpsc_pkg::SPD_HS) ? CHIRP_WAIT_CYC
                                                                 : BUS_RESET_CYC;
          end
          uhpsc_pkg::CMD_RESUME, uhpsc_pkg::CMD_RES_OP:
          begin
            state_r    <= uhpsc_pkg::HST_RESUME;
            tmr_load_r <= 1'b1;
            tmr_val_r  <= RESUME_CYC;
          end
          default:                 state_r <= state_r;
        endcase
      end
      else if (auto_run && !test_act_r)
      begin
        case (state_r)
          uhpsc_pkg::HST_WAIT_CON:
          begin
            if (DEV_CONNECT && chain_r)
            begin
              if (chain_tgt_r == uhpsc_pkg::HST_DISABLED)
              begin
                state_r <= uhpsc_pkg::HST_DISABLED;
                chain_r <= 1'b0;
              end
              else
              begin
                state_r    <= uhpsc_pkg::HST_RESET;
                rph_r      <= uhpsc_pkg::RPH_DRIVE;
                chirp_to_r <= 1'b0;
                tmr_load_r <= 1'b1;
                tmr_val_r  <= (nego_hi_r[5:4] == uhpsc_pkg::SPD_HS) ? CHIRP_WAIT_CYC
                                                                     : BUS_RESET_CYC;
              end
            end
          end
          uhpsc_pkg::HST_RESET:
          begin
            if (rph_r == uhpsc_pkg::RPH_DRIVE && nego_hi_r[5:4] == uhpsc_pkg::SPD_HS
                && DEV_CHIRP_DONE && (!chirp_to_r || nego_hi_r[uhpsc_pkg::CHIRP_WAIT_BIT]))
            begin
              rph_r      <= uhpsc_pkg::RPH_CHIRP;
              tmr_load_r <= 1'b1;
              tmr_val_r  <= HOST_CHIRP_CYC;
            end
            else if (rph_r == uhpsc_pkg::RPH_DRIVE && nego_hi_r[5:4] == uhpsc_pkg::SPD_HS
                     && tmr_hit && !chirp_to_r)
            begin
              chirp_to_r    <= 1'b1;
              chirp_err_p_r <= 1'b1;
              if (!nego_hi_r[uhpsc_pkg::CHIRP_WAIT_BIT])
              begin
                tmr_load_r <= 1'b1;
                tmr_val_r  <= BUS_RESET_CYC;
              end
            end
            else if ((rph_r == uhpsc_pkg::RPH_CHIRP && tmr_hit)
                     || (rph_r == uhpsc_pkg::RPH_DRIVE && tmr_hit
                         && (nego_hi_r[5:4] != uhpsc_pkg::SPD_HS
                             || (chirp_to_r && !nego_hi_r[uhpsc_pkg::CHIRP_WAIT_BIT]))))
            begin
              rph_r        <= uhpsc_pkg::RPH_DONE;
              rst_done_p_r <= 1'b1;
              if (chain_r)
              begin
                state_r <= chain_tgt_r;
                chain_r <= 1'b0;
              end
            end
          end
          uhpsc_pkg::HST_OPER:
          begin
            if (!DEV_CONNECT)
            begin
              state_r <= uhpsc_pkg::HST_WAIT_CON;
            end
          end
          uhpsc_pkg::HST_SUSPEND:
          begin
            if (wake_det && chain_r)
            begin
              state_r    <= uhpsc_pkg::HST_RESUME;
              tmr_load_r <= 1'b1;
              tmr_val_r  <= RESUME_CYC;
            end
          end
          uhpsc_pkg::HST_RESUME:
          begin
            if (tmr_hit && chain_r)
            begin
              state_r <= uhpsc_pkg::HST_OPER;
              chain_r <= 1'b0;
            end
          end
          default:
          begin
            state_r <= state_r;
          end
        endcase
      end
    end
  end

  // Line controls, registered before leaving the block
  always_comb
  begin
    line_nxt            = '0;
    line_nxt.speed      = nego_hi_r[5:4];
    line_nxt.conn_det   = auto_run & ~test_act_r;
    line_nxt.wake_det   = wake_det;
    line_nxt.bus_reset  = auto_run & (state_r == uhpsc_pkg::HST_RESET)
                        & (rph_r == uhpsc_pkg::RPH_DRIVE);
    line_nxt.host_chirp = auto_run & (state_r == uhpsc_pkg::HST_RESET)
                        & (rph_r == uhpsc_pkg::RPH_CHIRP);
    line_nxt.sof_en     = (state_r == uhpsc_pkg::HST_OPER) & ~test_act_r;
    line_nxt.suspend    = (state_r == uhpsc_pkg::HST_SUSPEND) & ~test_act_r;
    line_nxt.resume     = (state_r == uhpsc_pkg::HST_RESUME) & ~tmr_hit & ~test_act_r;
    if (test_act_r)
    begin
      line_nxt.speed     = uhpsc_pkg::SPD_HS;
      line_nxt.sof_en    = test_r[uhpsc_pkg::FORCE_EN_BIT];
      line_nxt.hs_rx     = test_r[uhpsc_pkg::SE0_NAK_BIT];
      line_nxt.drive_j   = test_r[uhpsc_pkg::TEST_J_BIT];
      line_nxt.drive_k   = test_r[uhpsc_pkg::TEST_K_BIT];
      line_nxt.pkt_frame = test_r[uhpsc_pkg::TEST_PKT_BIT];
      line_nxt.tx_pid    = test_r[uhpsc_pkg::TEST_PKT_BIT] ? uhpsc_pkg::DATA0_PID : 8'h00;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      LINE_CTRL <= '0;
    end
    else
    begin
      LINE_CTRL <= line_nxt;
    end
  end

endmodule : uhpsc_ctrl

// ---- uhpsc_dev_model.sv ----
// Behavioural downstream device on the host port
module uhpsc_dev_model (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire uhpsc_pkg::uhpsc_line_t line,
  input wire logic                   attach,
  input wire logic                   chirp_ok,
  input wire logic                   wake_req,
  output logic                       connect,
  output logic                       chirp_done,
  output logic                       remote_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wakeup signalling only while suspended
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) {connect, chirp_done, remote_wake} <= 3'h0;
    else {connect, chirp_done, remote_wake} <= {attach, chirp_ok, wake_req & line.suspend};
endmodule : uhpsc_dev_model

// ---- uhpsc_pkg.sv ----
// Constants and types of the host port state control block
package uhpsc_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned HALT_STOP_NS  = 100;
  localparam int unsigned HALT_STOP_CYC = (HALT_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W         = 24;
  localparam int unsigned HCNT_W        = 4;

  // Bus geometry: register index times four is the byte address
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 10;
  localparam logic [IDX_W-1:0] NEGO_LO_IDX   = 10'h160;
  localparam logic [IDX_W-1:0] NEGO_HI_IDX   = 10'h162;
  localparam logic [IDX_W-1:0] TEST_IDX      = 10'h164;
  localparam logic [IDX_W-1:0] PORT_STAT_IDX = 10'h166;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Field positions
  localparam int unsigned HALT_BIT       = 7;
  localparam int unsigned STATE_LSB      = 4;
  localparam int unsigned SPEED_LSB      = 4;
  localparam int unsigned CHIRP_WAIT_BIT = 1;
  localparam int unsigned WAKE_EN_BIT    = 0;
  localparam int unsigned ARM_BIT        = 7;
  localparam int unsigned FORCE_EN_BIT   = 4;
  localparam int unsigned SE0_NAK_BIT    = 3;
  localparam int unsigned TEST_J_BIT     = 2;
  localparam int unsigned TEST_K_BIT     = 1;
  localparam int unsigned TEST_PKT_BIT   = 0;
  localparam int unsigned CHIRP_ERR_BIT  = 0;
  localparam int unsigned WAKE_SEEN_BIT  = 1;
  localparam int unsigned RST_DONE_BIT   = 2;

  // Reset values and writable masks
  localparam logic [7:0] NEGO_HI_RST  = 8'h10;
  localparam logic [7:0] NEGO_HI_MASK = 8'h33;
  localparam logic [7:0] TEST_RST     = 8'h00;
  localparam logic [7:0] TEST_MASK    = 8'h9f;
  localparam logic [7:0] TEST_SEL_MSK = 8'h1f;
  localparam logic [7:0] STAT_RST     = 8'h00;
  localparam logic [7:0] DATA0_PID    = 8'hc3;

  localparam logic [1:0] SPD_HS = 2'h0;
  localparam logic [1:0] SPD_FS = 2'h1;
  localparam logic [1:0] SPD_LS = 2'h3;

  typedef enum logic [2:0] {
    HST_IDLE     = 3'b001,
    HST_WAIT_CON = 3'b010,
    HST_DISABLED = 3'b011,
    HST_RESET    = 3'b100,
    HST_OPER     = 3'b101,
    HST_SUSPEND  = 3'b110,
    HST_RESUME   = 3'b111
  } uhpsc_state_t;

  typedef enum logic [3:0] {
    CMD_IDLE     = 4'h1,
    CMD_WAIT_CON = 4'h2,
    CMD_DISABLED = 4'h3,
    CMD_RESET    = 4'h4,
    CMD_OPER     = 4'h5,
    CMD_SUSPEND  = 4'h6,
    CMD_RESUME   = 4'h7,
    CMD_WC_DIS   = 4'h9,
    CMD_WC_OP    = 4'ha,
    CMD_RST_OP   = 4'hc,
    CMD_SUS_OP   = 4'he,
    CMD_RES_OP   = 4'hf
  } uhpsc_cmd_t;

  typedef enum logic [1:0] {
    RPH_DRIVE = 2'b00,
    RPH_CHIRP = 2'b01,
    RPH_DONE  = 2'b10
  } uhpsc_rph_t;

  // Controls towards the transceiver and packet engine
  typedef struct packed {
    logic [7:0] tx_pid;
    logic       pkt_frame;
    logic [1:0] speed;
    logic       bus_reset;
    logic       host_chirp;
    logic       sof_en;
    logic       hs_rx;
    logic       drive_j;
    logic       drive_k;
    logic       suspend;
    logic       resume;
    logic       conn_det;
    logic       wake_det;
  } uhpsc_line_t;

endpackage : uhpsc_pkg

// ---- uhpsc_timer.sv ----
// Down counter shared by the timed host states
module uhpsc_timer (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           load,
  input  wire logic [uhpsc_pkg::TMR_W-1:0]    load_val,
  input  wire logic                           run,
  output logic                                expired
);

  logic [uhpsc_pkg::TMR_W-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
    end
    else if (load)
    begin
      cnt_r <= load_val;
    end
    else if (run && cnt_r != '0)
    begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign expired = (cnt_r == '0);

endmodule : uhpsc_timer
